// ---- dbgl2_trigger.sv ----
/*
 * Level-2 trigger combination and response selection, AXI4-Lite slave.
 * Assumes comparator results arrive from another domain; resetn is async.
 */
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
// What this block does
// [R1] Nominal logic-select bit 15 is ignored.
// [R2] Bit 31 selects logic and response.
// [R3] Bit 31 zero: all three conditions ANDed.
// [R4] Bit 31 one: PC or (range and data).
// [R5] Top bits pick show, halt or interrupt.
// [R6] Reserved code 11 is accepted and only flagged in status bit 3.
// [R7] Evaluate each clock; respond on rising trigger.
`timescale 1ns/1ps
module dbgl2_trigger (
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        program_counter_match,
	input  wire logic        address_range_match,
	input  wire logic        data_condition_match,
	output logic             debug_data_pins_show,
	output logic             halt_request,
	output logic             debug_irq_pulse,
	output logic             irq
);
	logic [2:0]  cond_s;
	logic [31:0] trig_def_reg, trig_def_next;
	logic [3:0]  status_reg, status_next;
	logic [3:0]  mask_reg, mask_next;
	logic        level2_reg, level2_next;
	logic        show_reg, show_next;
	logic        halt_reg, halt_next;
	logic        dirq_reg, dirq_next;
	logic        aw_reg, aw_next;
	logic        w_reg, w_next;
	logic [7:0]  awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0]  wstrb_reg, wstrb_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic        level2_now;
	logic        sel_or;
	logic [1:0]  resp_code;
	logic        do_write, do_read;
	logic [3:0]  ev;

	dbgl2_sync #(.W(3)) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.d       ({data_condition_match, address_range_match,
		            program_counter_match}),
		.q       (cond_s)
	);

	assign s_axi_awready = !aw_reg && !bvalid_reg;
	assign s_axi_wready  = !w_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign do_write = aw_reg && w_reg && !bvalid_reg;
	assign do_read  = s_axi_arvalid && !rvalid_reg;

	always_comb begin
		// [R2] Shared select bit.
		sel_or    = trig_def_reg[dbgl2_pkg::DBGL2_RESP_HI];
		resp_code = trig_def_reg[dbgl2_pkg::DBGL2_RESP_HI:
		                         dbgl2_pkg::DBGL2_RESP_LO];
		// [R1] Bit 15 never read here.
		// [R3] AND of all conditions.
		// [R4] PC or range-and-data.
		level2_now = sel_or ? (cond_s[0] | (cond_s[1] & cond_s[2]))
		                    : (cond_s[0] & cond_s[1] & cond_s[2]);
		level2_next = level2_now;
		show_next = 1'b0;
		halt_next = halt_reg;
		dirq_next = 1'b0;
		ev = 4'h0;
		// [R7] Respond on rising edge.
		if (level2_now && !level2_reg) begin
			// [R5] Response decode.
			unique case (resp_code)
				dbgl2_pkg::DBGL2_RESP_SHOW: begin
					show_next = 1'b1;
					ev[dbgl2_pkg::DBGL2_EV_SHOW] = 1'b1;
				end
				dbgl2_pkg::DBGL2_RESP_HALT: begin
					halt_next = 1'b1;
					ev[dbgl2_pkg::DBGL2_EV_HALT] = 1'b1;
				end
				dbgl2_pkg::DBGL2_RESP_IRQ: begin
					dirq_next = 1'b1;
					ev[dbgl2_pkg::DBGL2_EV_IRQ] = 1'b1;
				end
				dbgl2_pkg::DBGL2_RESP_RSVD: begin
					// [R6] Reserved code flagged only.
					ev[dbgl2_pkg::DBGL2_EV_RSVD] = 1'b1;
				end
			endcase
		end
		// Halt holds until software changes the response code.
		if (resp_code != dbgl2_pkg::DBGL2_RESP_HALT) begin
			halt_next = 1'b0;
		end
	end

	always_comb begin
		aw_next = aw_reg;
		w_next = w_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		trig_def_next = trig_def_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (do_write) begin
			aw_next = 1'b0;
			w_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = dbgl2_pkg::DBGL2_RESP_OKAY;
			unique case (awaddr_reg[7:2])
				dbgl2_pkg::DBGL2_OFF_TRIG_DEF[7:2]: begin
					for (int b = 0; b < 4; b++) begin
						if (wstrb_reg[b]) begin
							trig_def_next[b*8 +: 8] = wdata_reg[b*8 +: 8];
						end
					end
				end
				dbgl2_pkg::DBGL2_OFF_MASK[7:2]: begin
					if (wstrb_reg[0]) begin
						mask_next = wdata_reg[3:0];
					end
				end
				dbgl2_pkg::DBGL2_OFF_STATUS[7:2],
				dbgl2_pkg::DBGL2_OFF_LIVE[7:2]: begin
				end
				default: begin
					bresp_next = dbgl2_pkg::DBGL2_RESP_SLVERR;
				end
			endcase
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (do_read) begin
			rvalid_next = 1'b1;
			rresp_next = dbgl2_pkg::DBGL2_RESP_OKAY;
			rdata_next = 32'h0000_0000;
			unique case (s_axi_araddr[7:2])
				dbgl2_pkg::DBGL2_OFF_TRIG_DEF[7:2]: begin
					rdata_next = trig_def_reg;
				end
				dbgl2_pkg::DBGL2_OFF_STATUS[7:2]: begin
					rdata_next[3:0] = status_reg;
					status_next = 4'h0;
				end
				dbgl2_pkg::DBGL2_OFF_MASK[7:2]: begin
					rdata_next[3:0] = mask_reg;
				end
				dbgl2_pkg::DBGL2_OFF_LIVE[7:2]: begin
					rdata_next[2:0] = {halt_reg, cond_s[1], level2_reg};
				end
				default: begin
					rresp_next = dbgl2_pkg::DBGL2_RESP_SLVERR;
				end
			endcase
		end
		// New events win over a read clear in the same cycle.
		status_next = status_next | ev;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			trig_def_reg <= dbgl2_pkg::DBGL2_TRIG_DEF_RST;
			status_reg <= 4'h0;
			mask_reg <= 4'h0;
			level2_reg <= 1'b0;
			show_reg <= 1'b0;
			halt_reg <= 1'b0;
			dirq_reg <= 1'b0;
			aw_reg <= 1'b0;
			w_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= 2'h0;
		end else begin
			trig_def_reg <= trig_def_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			level2_reg <= level2_next;
			show_reg <= show_next;
			halt_reg <= halt_next;
			dirq_reg <= dirq_next;
			aw_reg <= aw_next;
			w_reg <= w_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign debug_data_pins_show = show_reg;
	assign halt_request = halt_reg;
	assign debug_irq_pulse = dirq_reg;
	assign irq = |(status_reg & mask_reg);
endmodule : dbgl2_trigger

// ---- dbgl2_pkg.sv ----
/*
 * Shared constants for the level-2 debug trigger block.
 * Assumes a 32-bit AXI4-Lite register bus and a single system clock.
 */
package dbgl2_pkg;
	localparam logic [7:0]  DBGL2_OFF_TRIG_DEF = 8'h00;
	localparam logic [7:0]  DBGL2_OFF_STATUS   = 8'h04;
	localparam logic [7:0]  DBGL2_OFF_MASK     = 8'h08;
	localparam logic [7:0]  DBGL2_OFF_LIVE     = 8'h0c;
	localparam logic [31:0] DBGL2_TRIG_DEF_RST = 32'h0000_0000;
	localparam int          DBGL2_RESP_HI      = 31;
	localparam int          DBGL2_RESP_LO      = 30;
	localparam int          DBGL2_L2_SEL_NOM   = 15;
	localparam logic [1:0]  DBGL2_RESP_SHOW    = 2'h0;
	localparam logic [1:0]  DBGL2_RESP_HALT    = 2'h1;
	localparam logic [1:0]  DBGL2_RESP_IRQ     = 2'h2;
	localparam logic [1:0]  DBGL2_RESP_RSVD    = 2'h3;
	localparam int          DBGL2_EV_SHOW      = 0;
	localparam int          DBGL2_EV_HALT      = 1;
	localparam int          DBGL2_EV_IRQ       = 2;
	localparam int          DBGL2_EV_RSVD      = 3;
	localparam int          DBGL2_NEV          = 4;
	localparam logic [1:0]  DBGL2_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  DBGL2_RESP_SLVERR  = 2'h2;
endpackage : dbgl2_pkg

// ---- dbgl2_sync.sv ----
/*
 * Three-stage synchroniser with agreement of the last two stages.
 * Assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module dbgl2_sync #(
	parameter int W = 3
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	always_comb begin
		q_next = q_reg;
		for (int i = 0; i < W; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				q_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_reg  <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg  <= q_next;
		end
	end

	assign q = q_reg;
endmodule : dbgl2_sync

// ---- dbgl2_cmp_model.sv ----
/* Comparator model driving the three match results.
   Assumes the bench sets want just after clock edges. */
`timescale 1ns/1ps
module dbgl2_cmp_model (
	input  wire logic       clk_sys,
	input  wire logic [2:0] want,
	output logic      [2:0] match
);
	// Results move only on edges, as the core comparators do.
	always @(posedge clk_sys) begin
		match <= want;
	end
endmodule : dbgl2_cmp_model

// ---- dbgl2_trigger_asserts.sv ----
/* Port checker for the level-2 trigger block.
   Assumes match inputs stay steady well past each response. */
`timescale 1ns/1ps
module dbgl2_trigger_asserts (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic program_counter_match,
	input wire logic address_range_match,
	input wire logic data_condition_match,
	input wire logic debug_data_pins_show,
	input wire logic halt_request,
	input wire logic debug_irq_pulse
);
	logic t_and;
	logic t_or;
	assign t_and = program_counter_match && address_range_match
		&& data_condition_match;
	assign t_or = program_counter_match
		|| (address_range_match && data_condition_match);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_show_and: assert property (debug_data_pins_show |-> t_and)
		else $error("show without all conditions");
	a_halt_and: assert property ($rose(halt_request) |-> t_and)
		else $error("halt without all conditions");
	a_irq_or: assert property (debug_irq_pulse |-> t_or)
		else $error("interrupt without its condition");
	a_show_once: assert property (debug_data_pins_show |=>
		!debug_data_pins_show) else $error("show pulse too long");
	a_irq_once: assert property (debug_irq_pulse |=>
		!debug_irq_pulse) else $error("interrupt pulse too long");
	a_one_resp: assert property (debug_data_pins_show |->
		!debug_irq_pulse && !$rose(halt_request))
		else $error("two responses at once");
	c_show: cover property (debug_data_pins_show);
	c_halt: cover property ($rose(halt_request));
	c_irq: cover property (debug_irq_pulse);
endmodule : dbgl2_trigger_asserts

bind dbgl2_trigger dbgl2_trigger_asserts u_dbgl2_trigger_asserts (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.program_counter_match(program_counter_match),
	.address_range_match(address_range_match),
	.data_condition_match(data_condition_match),
	.debug_data_pins_show(debug_data_pins_show),
	.halt_request(halt_request),
	.debug_irq_pulse(debug_irq_pulse)
);

// ---- testbench.sv ----
/* Self-checking bench for the level-2 trigger block.
   Assumes the comparator model and the bound checker. */
`timescale 1ns/1ps
module testbench;
	logic        clk_sys, resetn, irq, halt_request;
	logic        debug_data_pins_show, debug_irq_pulse;
	logic        program_counter_match, address_range_match;
	logic        data_condition_match;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat, mask, d, e;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rp, bp, c;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready;
	logic [2:0]  want, match, v;
	integer      err_count, checked, seed;
	integer      n_show = 0;
	integer      n_irq = 0;
	integer      x_show, x_irq;
	assign {program_counter_match, address_range_match,
		data_condition_match} = match;
	dbgl2_cmp_model u_dbgl2_cmp_model (.clk_sys(clk_sys), .want(want),
		.match(match));
	dbgl2_trigger u_dbgl2_trigger (
		.clk_sys               (clk_sys),
		.resetn                (resetn),
		.s_axi_awaddr          (s_axi_awaddr),
		.s_axi_awvalid         (s_axi_awvalid),
		.s_axi_awready         (s_axi_awready),
		.s_axi_wdata           (s_axi_wdata),
		.s_axi_wstrb           (s_axi_wstrb),
		.s_axi_wvalid          (s_axi_wvalid),
		.s_axi_wready          (s_axi_wready),
		.s_axi_bresp           (s_axi_bresp),
		.s_axi_bvalid          (s_axi_bvalid),
		.s_axi_bready          (s_axi_bready),
		.s_axi_araddr          (s_axi_araddr),
		.s_axi_arvalid         (s_axi_arvalid),
		.s_axi_arready         (s_axi_arready),
		.s_axi_rdata           (s_axi_rdata),
		.s_axi_rresp           (s_axi_rresp),
		.s_axi_rvalid          (s_axi_rvalid),
		.s_axi_rready          (s_axi_rready),
		.program_counter_match (program_counter_match),
		.address_range_match   (address_range_match),
		.data_condition_match  (data_condition_match),
		.debug_data_pins_show  (debug_data_pins_show),
		.halt_request          (halt_request),
		.debug_irq_pulse       (debug_irq_pulse),
		.irq                   (irq)
	);
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, s, x);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] w);
		logic da, dw, gb;
		da = 0;
		dw = 0;
		gb = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!gb) begin
			@(negedge clk_sys);
			da = da | s_axi_awready;
			dw = dw | s_axi_wready;
			gb = s_axi_bvalid;
			bp = s_axi_bresp;
			@(posedge clk_sys);
			if (da) s_axi_awvalid <= 0;
			if (dw) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a);
		logic ga, gr;
		ga = 0;
		gr = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!gr) begin
			@(negedge clk_sys);
			ga = ga | s_axi_arready;
			gr = s_axi_rvalid;
			rdat = s_axi_rdata;
			rp = s_axi_rresp;
			@(posedge clk_sys);
			if (ga) s_axi_arvalid <= 0;
		end
		s_axi_rready <= 0;
	endtask : bus_rd
	function automatic logic [31:0] ev(input logic [1:0] k,
		input logic [2:0] m);
		logic t;
		t = k[1] ? (m[2] | (m[1] & m[0])) : &m;
		return t ? 32'h1 << k : 32'h0;
	endfunction : ev
	always @(negedge clk_sys) begin
		if (debug_data_pins_show) n_show <= n_show + 1;
		if (debug_irq_pulse) n_irq <= n_irq + 1;
	end
	initial begin
		#50000;
		err_count++;
		close_out();
	end
	initial begin
		seed = 32'h07e97daa;
		{err_count, checked, x_show, x_irq, want, resetn} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge clk_sys);
		resetn <= 1;
		mask = $random(seed) & 32'hf;
		bus_wr(dbgl2_pkg::DBGL2_OFF_MASK, mask);
		chk(32'(bp), 32'(dbgl2_pkg::DBGL2_RESP_OKAY));
		bus_rd(dbgl2_pkg::DBGL2_OFF_MASK);
		chk(rdat, mask);
		bus_wr(8'h14, 32'h5a5a_5a5a);
		chk(32'(bp), 32'(dbgl2_pkg::DBGL2_RESP_SLVERR));
		bus_rd(8'h10);
		chk(32'(rp), 32'(dbgl2_pkg::DBGL2_RESP_SLVERR));
		for (int i = 0; i < 32; i++) begin
			c = 2'(i % 3);
			v = i < 24 ? 3'(i / 3) : 3'($random(seed));
			want <= 3'h0;
			repeat (10) @(posedge clk_sys);
			d = $random(seed);
			d[31:30] = c;
			bus_wr(dbgl2_pkg::DBGL2_OFF_TRIG_DEF, d);
			bus_rd(dbgl2_pkg::DBGL2_OFF_TRIG_DEF);
			chk(rdat, d);
			bus_rd(dbgl2_pkg::DBGL2_OFF_STATUS);
			want <= v;
			repeat (12) @(posedge clk_sys);
			e = ev(c, v);
			chk(32'(irq), 32'(|(e & mask)));
			chk(32'(halt_request), 32'(e[1]));
			bus_rd(dbgl2_pkg::DBGL2_OFF_STATUS);
			chk(rdat, e);
			bus_rd(dbgl2_pkg::DBGL2_OFF_LIVE);
			chk(rdat, {29'h0, e[1], v[1], |e});
			x_show = x_show + e[0];
			x_irq = x_irq + e[2];
			chk(n_show, x_show);
			chk(n_irq, x_irq);
		end
		s_axi_wstrb <= 4'h3;
		bus_wr(dbgl2_pkg::DBGL2_OFF_TRIG_DEF, 32'hffff_ffff);
		s_axi_wstrb <= 4'hf;
		bus_rd(dbgl2_pkg::DBGL2_OFF_TRIG_DEF);
		chk(rdat, {d[31:16], 16'hffff});
		repeat (8) @(posedge clk_sys);
		chk(n_show, x_show);
		chk(n_irq, x_irq);
		want <= 3'h0;
		repeat (8) @(posedge clk_sys);
		resetn <= 0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1;
		chk(32'(halt_request), 32'h0);
		bus_rd(dbgl2_pkg::DBGL2_OFF_TRIG_DEF);
		chk(rdat, dbgl2_pkg::DBGL2_TRIG_DEF_RST);
		bus_rd(dbgl2_pkg::DBGL2_OFF_STATUS);
		chk(rdat, 32'h0);
		chk(32'(irq), 32'h0);
		close_out();
	end
endmodule : testbench
